/* rtl/col_loader_pkg.sv */
package col_loader_pkg;
    localparam int          PIX_W          = 10;
    localparam int          NUM_CH         = 6;
    localparam int          CH_W           = 3;
    localparam logic [2:0]  CH_LEFT        = 3'h0;
    localparam logic [2:0]  CH_RIGHT       = 3'h5;
    localparam int          SER_BITS       = 12;
    localparam int          SER_CNT_W      = 4;
    localparam int          SER_SEL_POS    = 11;
    localparam int          DAC_W          = 8;
    localparam int          FIFO_DEPTH     = 8;
    localparam int          CLK_PERIOD_NS  = 5;
    localparam int          SCLK_HIGH_NS   = 15;
    localparam int          SCLK_HALF_CYC  = (SCLK_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          PCLK_HALF_NS   = 20;
    localparam int          PCLK_HALF_CYC  = (PCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0]  COL_RST        = 10'h000;
    localparam logic [7:0]  DAC_RST        = 8'h00;
    localparam logic        MODE_NORMAL    = 1'b0;
endpackage

/* rtl/col_link_if.sv */
`timescale 1ns/10ps
interface col_link_if;
    import col_loader_pkg::*;
    logic             pix_clk;
    logic [PIX_W-1:0] pixel_word_in;
    logic             sequence_start;
    logic             output_transfer;
    logic             polarity_invert;
    logic             edge_phase;
    logic             scan_dir;
    logic             ser_clk;
    logic             ctrl_serial_in;
    logic             ctrl_frame_enable;
    logic             test_mode_force;
    modport timing_ctrl (
        output pix_clk, pixel_word_in, sequence_start, output_transfer, polarity_invert,
               edge_phase, scan_dir, ser_clk, ctrl_serial_in, ctrl_frame_enable, test_mode_force
    );
    modport column_drv (
        input  pix_clk, pixel_word_in, sequence_start, output_transfer, polarity_invert,
               edge_phase, scan_dir, ser_clk, ctrl_serial_in, ctrl_frame_enable, test_mode_force
    );
endinterface

/* rtl/column_driver_end.sv */
`timescale 1ns/10ps

module word_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk_i,
    input  wire logic             srst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [AW:0]      cnt_ff;
    logic             push;
    logic             pop;

    assign in_ready_o  = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_ff != '0);
    assign out_data_o  = mem_ff[rd_ff];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // word_fifo

module column_driver_end (
    input  wire logic                                      core_clk_i,
    input  wire logic                                      srst_i,
    col_link_if.column_drv                                 link,
    input  wire logic                                      mode_prog_i,
    output logic [col_loader_pkg::NUM_CH*col_loader_pkg::PIX_W-1:0] column_outputs_o,
    output logic                                           column_polarity_o,
    output logic [col_loader_pkg::DAC_W-1:0]               dac_out0_o,
    output logic [col_loader_pkg::DAC_W-1:0]               dac_out1_o,
    output logic                                           output_mode_o,
    output logic                                           load_overflow_o
);
    import col_loader_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int SW = PIX_W + 10;
    logic [SW-1:0] meta_ff;
    logic [SW-1:0] sync_ff;
    logic          pclk_d_ff;
    logic          sclk_d_ff;
    logic          fen_d_ff;

    always_ff @(posedge core_clk_i) begin
        meta_ff <= {link.pixel_word_in, link.pix_clk, link.sequence_start, link.output_transfer,
                    link.polarity_invert, link.edge_phase, link.scan_dir, link.ser_clk,
                    link.ctrl_serial_in, link.ctrl_frame_enable, link.test_mode_force};
        sync_ff <= meta_ff;
    end

    logic [PIX_W-1:0] word_s;
    logic pclk_s, start_s, xfer_s, pol_s, phase_s, dir_s, sclk_s, sdata_s, fen_s, test_s;
    assign {word_s, pclk_s, start_s, xfer_s, pol_s, phase_s, dir_s,
            sclk_s, sdata_s, fen_s, test_s} = sync_ff;

    always_ff @(posedge core_clk_i) begin
        pclk_d_ff <= pclk_s;
        sclk_d_ff <= sclk_s;
        fen_d_ff  <= fen_s;
    end

    logic pclk_rise, pclk_fall, act_edge;
    assign pclk_rise = pclk_s & ~pclk_d_ff;
    assign pclk_fall = ~pclk_s & pclk_d_ff;
    assign act_edge  = phase_s ? pclk_rise : pclk_fall;

    // ------------------------------------------------------------
    // Loading sequence
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        LD_IDLE  = 3'b001,
        LD_ARMED = 3'b010,
        LD_RUN   = 3'b100
    } ld_state_t;

    ld_state_t        ld_state_ff;
    logic [CH_W-1:0]  idx_ff;
    logic [CH_W-1:0]  cnt_ff;
    logic             dir_ff;
    logic [CH_W-1:0]  cap_ch;
    logic             cap_valid;
    logic             fifo_in_ready;

    function automatic logic [CH_W-1:0] step_ch(input logic [CH_W-1:0] ch, input logic dir);
        step_ch = dir ? ch - 1'b1 : ch + 1'b1;
    endfunction

    assign cap_ch    = (ld_state_ff == LD_ARMED) ? (dir_s ? CH_RIGHT : CH_LEFT) : idx_ff;
    assign cap_valid = act_edge & (ld_state_ff != LD_IDLE);

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            ld_state_ff <= LD_IDLE;
            idx_ff      <= CH_LEFT;
            cnt_ff      <= '0;
            dir_ff      <= 1'b0;
        end else if (act_edge) begin
            case (ld_state_ff)
                LD_IDLE: begin
                    if (start_s) begin
                        ld_state_ff <= LD_ARMED;
                    end
                end
                LD_ARMED: begin
                    dir_ff      <= dir_s;
                    idx_ff      <= step_ch(cap_ch, dir_s);
                    cnt_ff      <= CH_W'(1);
                    ld_state_ff <= start_s ? LD_ARMED : LD_RUN;
                end
                LD_RUN: begin
                    idx_ff <= step_ch(idx_ff, dir_ff);
                    cnt_ff <= cnt_ff + 1'b1;
                    if (start_s) begin
                        ld_state_ff <= LD_ARMED;
                    end else if (cnt_ff == CH_W'(NUM_CH-1)) begin
                        ld_state_ff <= LD_IDLE;
                    end
                end
                default: ld_state_ff <= LD_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            load_overflow_o <= 1'b0;
        end else if (cap_valid & ~fifo_in_ready) begin
            load_overflow_o <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Word buffer and channel latches
    // ------------------------------------------------------------
    logic                   fifo_out_valid;
    logic                   fifo_out_ready;
    logic [CH_W+PIX_W-1:0]  fifo_out_data;
    logic [PIX_W-1:0]       latch_ff [NUM_CH];
    logic                   xfer_seen_ff;
    logic                   xfer_det_ff;
    logic                   xfer_go;

    word_fifo #(
        .WIDTH(CH_W + PIX_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .in_valid_i (cap_valid),
        .in_ready_o (fifo_in_ready),
        .in_data_i  ({cap_ch, word_s}),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o (fifo_out_data)
    );

    assign xfer_go        = pclk_rise & xfer_det_ff;
    assign fifo_out_ready = ~xfer_go;

    generate
        for (genvar c = 0; c < NUM_CH; c++) begin : g_latch
            always_ff @(posedge core_clk_i) begin
                if (srst_i) begin
                    latch_ff[c] <= COL_RST;
                end else if (fifo_out_valid & fifo_out_ready &
                             (fifo_out_data[CH_W+PIX_W-1:PIX_W] == CH_W'(c))) begin
                    latch_ff[c] <= fifo_out_data[PIX_W-1:0];
                end
            end
            always_ff @(posedge core_clk_i) begin
                if (srst_i) begin
                    column_outputs_o[c*PIX_W +: PIX_W] <= COL_RST;
                end else if (xfer_go) begin
                    column_outputs_o[c*PIX_W +: PIX_W] <= latch_ff[c];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Transfer detect and polarity pipeline
    // ------------------------------------------------------------
    logic pol_stage_ff;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            xfer_seen_ff <= 1'b0;
            xfer_det_ff  <= 1'b0;
        end else if (pclk_rise) begin
            xfer_seen_ff <= xfer_s;
            xfer_det_ff  <= xfer_s & ~xfer_seen_ff;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            pol_stage_ff      <= 1'b0;
            column_polarity_o <= 1'b0;
        end else if (xfer_go) begin
            pol_stage_ff      <= pol_s;
            column_polarity_o <= pol_stage_ff;
        end
    end

    // ------------------------------------------------------------
    // Serial control loader
    // ------------------------------------------------------------
    logic [SER_BITS-1:0]  ser_sh_ff;
    logic [SER_CNT_W-1:0] ser_cnt_ff;
    logic                 sclk_rise;
    logic                 fen_fall;
    logic                 fen_rise;

    assign sclk_rise = sclk_s & ~sclk_d_ff;
    assign fen_fall  = ~fen_s & fen_d_ff;
    assign fen_rise  = fen_s & ~fen_d_ff;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            ser_sh_ff  <= '0;
            ser_cnt_ff <= '0;
        end else if (fen_fall) begin
            ser_cnt_ff <= '0;
        end else if (sclk_rise & ~fen_s & (ser_cnt_ff != SER_CNT_W'(SER_BITS))) begin
            ser_sh_ff  <= {ser_sh_ff[SER_BITS-2:0], sdata_s};
            ser_cnt_ff <= ser_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            dac_out0_o <= DAC_RST;
            dac_out1_o <= DAC_RST;
        end else if (fen_rise & (ser_cnt_ff == SER_CNT_W'(SER_BITS))) begin
            if (ser_sh_ff[SER_SEL_POS]) begin
                dac_out1_o <= ser_sh_ff[DAC_W-1:0];
            end else begin
                dac_out0_o <= ser_sh_ff[DAC_W-1:0];
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            output_mode_o <= MODE_NORMAL;
        end else begin
            output_mode_o <= test_s ? MODE_NORMAL : mode_prog_i;
        end
    end
endmodule // column_driver_end

/* rtl/timing_ctrl_end.sv */
`timescale 1ns/10ps
module timing_ctrl_end #(
    parameter int PCLK_HALF = col_loader_pkg::PCLK_HALF_CYC,
    parameter int SCLK_HALF = col_loader_pkg::SCLK_HALF_CYC
) (
    input  wire logic                              core_clk_i,
    input  wire logic                              srst_i,
    col_link_if.timing_ctrl                        link,
    input  wire logic                              pix_valid_i,
    output logic                                   pix_ready_o,
    input  wire logic [col_loader_pkg::PIX_W-1:0]  pix_word_i,
    input  wire logic                              edge_phase_i,
    input  wire logic                              scan_dir_i,
    input  wire logic                              polarity_i,
    input  wire logic                              test_mode_i,
    input  wire logic                              dac_valid_i,
    output logic                                   dac_ready_o,
    input  wire logic                              dac_sel_i,
    input  wire logic [col_loader_pkg::DAC_W-1:0]  dac_code_i,
    output logic                                   line_busy_o
);
    import col_loader_pkg::*;

    // ------------------------------------------------------------
    // Pixel clock divider
    // ------------------------------------------------------------
    logic [7:0] pdiv_ff;
    logic       ptick;
    logic       pclk_ff;
    logic       slot;

    assign ptick = (pdiv_ff == 8'(PCLK_HALF - 1));
    assign slot  = ptick & (pclk_ff == link.edge_phase);

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            pdiv_ff <= '0;
            pclk_ff <= 1'b0;
        end else begin
            pdiv_ff <= ptick ? '0 : pdiv_ff + 1'b1;
            if (ptick) begin
                pclk_ff <= ~pclk_ff;
            end
        end
    end

    // ------------------------------------------------------------
    // Line sequencer
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        H_IDLE  = 4'b0001,
        H_START = 4'b0010,
        H_LOAD  = 4'b0100,
        H_XFER  = 4'b1000
    } h_state_t;

    h_state_t         h_ff;
    logic [2:0]       hcnt_ff;
    logic [PIX_W-1:0] hold_ff;
    logic             hold_full_ff;
    logic [PIX_W-1:0] word_ff;
    logic             start_ff;
    logic             xfer_ff;
    logic             pol_ff;
    logic             take;

    assign take = slot & ((h_ff == H_START) | (h_ff == H_LOAD));

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            hold_full_ff <= 1'b0;
            hold_ff      <= COL_RST;
            pix_ready_o  <= 1'b0;
        end else begin
            if (pix_valid_i & pix_ready_o) begin
                hold_ff      <= pix_word_i;
                hold_full_ff <= 1'b1;
            end else if (take) begin
                hold_full_ff <= 1'b0;
            end
            pix_ready_o <= ~hold_full_ff & ~(pix_valid_i & pix_ready_o);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            h_ff     <= H_IDLE;
            hcnt_ff  <= '0;
            word_ff  <= COL_RST;
            start_ff <= 1'b0;
            xfer_ff  <= 1'b0;
            pol_ff   <= 1'b0;
        end else if (slot) begin
            case (h_ff)
                H_IDLE: begin
                    xfer_ff <= 1'b0;
                    if (hold_full_ff) begin
                        start_ff <= 1'b1;
                        h_ff     <= H_START;
                    end
                end
                H_START: begin
                    start_ff <= 1'b0;
                    word_ff  <= hold_ff;
                    h_ff     <= H_LOAD;
                    hcnt_ff  <= 3'd1;
                end
                H_LOAD: begin
                    word_ff <= hold_ff;
                    hcnt_ff <= hcnt_ff + 1'b1;
                    if (hcnt_ff == 3'(NUM_CH-1)) begin
                        h_ff    <= H_XFER;
                        hcnt_ff <= '0;
                    end
                end
                H_XFER: begin
                    xfer_ff <= 1'b1;
                    pol_ff  <= polarity_i;
                    hcnt_ff <= hcnt_ff + 1'b1;
                    if (hcnt_ff == 3'd2) begin
                        xfer_ff <= 1'b0;
                        h_ff    <= H_IDLE;
                    end
                end
                default: h_ff <= H_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            line_busy_o <= 1'b0;
        end else begin
            line_busy_o <= (h_ff != H_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Serial control writer
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE  = 3'b001,
        S_SHIFT = 3'b010,
        S_END   = 3'b100
    } s_state_t;

    s_state_t             s_ff;
    logic [7:0]           sdiv_ff;
    logic                 stick;
    logic [SER_BITS-1:0]  ssh_ff;
    logic [SER_CNT_W-1:0] scnt_ff;
    logic                 sclk_ff;
    logic                 sdat_ff;
    logic                 fen_ff;

    assign stick = (sdiv_ff == 8'(SCLK_HALF - 1));

    always_ff @(posedge core_clk_i) begin
        if (srst_i | (s_ff == S_IDLE)) begin
            sdiv_ff <= '0;
        end else begin
            sdiv_ff <= stick ? '0 : sdiv_ff + 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            s_ff        <= S_IDLE;
            ssh_ff      <= '0;
            scnt_ff     <= '0;
            sclk_ff     <= 1'b0;
            sdat_ff     <= 1'b0;
            fen_ff      <= 1'b1;
            dac_ready_o <= 1'b0;
        end else begin
            case (s_ff)
                S_IDLE: begin
                    dac_ready_o <= ~(dac_valid_i & dac_ready_o);
                    if (dac_valid_i & dac_ready_o) begin
                        ssh_ff  <= {dac_sel_i, 3'h0, dac_code_i};
                        sdat_ff <= dac_sel_i;
                        fen_ff  <= 1'b0;
                        scnt_ff <= '0;
                        s_ff    <= S_SHIFT;
                    end
                end
                S_SHIFT: begin
                    if (stick & ~sclk_ff) begin
                        sclk_ff <= 1'b1;
                        scnt_ff <= scnt_ff + 1'b1;
                    end else if (stick) begin
                        sclk_ff <= 1'b0;
                        ssh_ff  <= {ssh_ff[SER_BITS-2:0], 1'b0};
                        sdat_ff <= ssh_ff[SER_BITS-2];
                        if (scnt_ff == SER_CNT_W'(SER_BITS)) begin
                            s_ff <= S_END;
                        end
                    end
                end
                S_END: begin
                    if (stick) begin
                        fen_ff <= 1'b1;
                        s_ff   <= S_IDLE;
                    end
                end
                default: s_ff <= S_IDLE;
            endcase
        end
    end

    assign link.pix_clk           = pclk_ff;
    assign link.pixel_word_in     = word_ff;
    assign link.sequence_start    = start_ff;
    assign link.output_transfer   = xfer_ff;
    assign link.polarity_invert   = pol_ff;
    assign link.edge_phase        = edge_phase_i;
    assign link.scan_dir          = scan_dir_i;
    assign link.ser_clk           = sclk_ff;
    assign link.ctrl_serial_in    = sdat_ff;
    assign link.ctrl_frame_enable = fen_ff;
    assign link.test_mode_force   = test_mode_i;
endmodule // timing_ctrl_end

/* test/col_loader_monitor.sv */
`timescale 1ns/10ps
module col_loader_monitor (
    input  wire logic core_clk_i,
    input  wire logic srst_i,
    input  wire logic pix_clk,
    input  wire logic sequence_start,
    input  wire logic output_transfer,
    input  wire logic polarity_invert,
    input  wire logic ser_clk,
    input  wire logic ctrl_serial_in,
    input  wire logic ctrl_frame_enable
);
    logic [3:0] bit_cnt_ff;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    // ----------
    // Serial bit counter
    // ----------
    always_ff @(posedge core_clk_i) begin
        if (srst_i || $fell(ctrl_frame_enable)) begin
            bit_cnt_ff <= 4'h0;
        end else if (!ctrl_frame_enable && $rose(ser_clk)) begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end
    end
    // ----------
    // Link checks
    // ----------
    property p_ser_count; $rose(ctrl_frame_enable) |-> bit_cnt_ff == 4'hc; endproperty
    a_ser_count: assert property (p_ser_count) else $error("serial word length wrong");
    property p_idle_low; ctrl_frame_enable |-> !ser_clk; endproperty
    a_idle_low: assert property (p_idle_low) else $error("serial clock active outside frame");
    property p_frame_setup; $fell(ctrl_frame_enable) |-> !ser_clk [*2]; endproperty
    a_frame_setup: assert property (p_frame_setup) else $error("frame start setup short");
    property p_sdi_hold; $rose(ser_clk) |-> $stable(ctrl_serial_in) [*2]; endproperty
    a_sdi_hold: assert property (p_sdi_hold) else $error("serial data moved at clock");
    property p_xfr_hold; $rose(output_transfer) |-> output_transfer [*4]; endproperty
    a_xfr_hold: assert property (p_xfr_hold) else $error("transfer strobe too short");
    property p_start_hold; $rose(sequence_start) |-> sequence_start [*6]; endproperty
    a_start_hold: assert property (p_start_hold) else $error("start strobe too short");
    property p_pclk_half; $changed(pix_clk) |=> $stable(pix_clk) [*3]; endproperty
    a_pclk_half: assert property (p_pclk_half) else $error("pixel clock half too short");
    property p_pol_stable; output_transfer && $past(output_transfer) |-> $stable(polarity_invert); endproperty
    a_pol_stable: assert property (p_pol_stable) else $error("polarity moved in transfer");
endmodule // col_loader_monitor

/* test/test_decimating_column_loader.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module test_decimating_column_loader;
    import col_loader_pkg::*;
    logic core_clk_i = 1'b0, srst_i = 1'b1, pix_valid_i = 1'b0, edge_phase_i = 1'b0, scan_dir_i = 1'b0;
    logic polarity_i = 1'b0, test_mode_i = 1'b0, dac_valid_i = 1'b0, dac_sel_i = 1'b0, mode_prog_i = 1'b0;
    logic [PIX_W-1:0]        pix_word_i = 10'h000;
    logic [DAC_W-1:0]        dac_code_i = 8'h00;
    logic                    pix_ready_o, dac_ready_o, line_busy_o, column_polarity_o, output_mode_o, load_overflow_o;
    logic [NUM_CH*PIX_W-1:0] column_outputs_o, col_seen = '0;
    logic [DAC_W-1:0]        dac_out0_o, dac_out1_o;
    logic [NUM_CH*PIX_W:0]   col_q[$];
    logic [15:0]             dac_q[$], dac_seen = 16'h0000, dac_model = 16'h0000, rnd = 16'h0044;
    logic                    pol_prev = 1'b0;
    int                      n_errors = 0, total_checks = 0;
    always #2.5 core_clk_i = ~core_clk_i;
    col_link_if link();
    timing_ctrl_end i_timing_ctrl_end (.core_clk_i, .srst_i, .link(link), .pix_valid_i, .pix_ready_o, .pix_word_i,
        .edge_phase_i, .scan_dir_i, .polarity_i, .test_mode_i, .dac_valid_i, .dac_ready_o, .dac_sel_i,
        .dac_code_i, .line_busy_o);
    column_driver_end i_column_driver_end (.core_clk_i, .srst_i, .link(link), .mode_prog_i, .column_outputs_o,
        .column_polarity_o, .dac_out0_o, .dac_out1_o, .output_mode_o, .load_overflow_o);
    col_loader_monitor i_col_loader_monitor (.core_clk_i, .srst_i, .pix_clk(link.pix_clk),
        .sequence_start(link.sequence_start), .output_transfer(link.output_transfer),
        .polarity_invert(link.polarity_invert), .ser_clk(link.ser_clk), .ctrl_serial_in(link.ctrl_serial_in),
        .ctrl_frame_enable(link.ctrl_frame_enable));
    // ----------
    // Stimulus helpers
    // ----------
    function automatic logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic send_line(input logic ep, input logic sd, input logic pol);
        logic [NUM_CH*PIX_W-1:0] exp;
        int c;
        @(posedge core_clk_i);
        edge_phase_i <= ep;
        scan_dir_i <= sd;
        polarity_i <= pol;
        repeat (4) @(posedge core_clk_i);
        for (int i = 0; i < NUM_CH; i++) begin
            rnd = next_rand(rnd);
            c = sd ? NUM_CH - 1 - i : i;
            exp[c*PIX_W +: PIX_W] = rnd[PIX_W-1:0];
            pix_valid_i <= 1'b1;
            pix_word_i <= rnd[PIX_W-1:0];
            do @(posedge core_clk_i); while (pix_ready_o !== 1'b1);
        end
        pix_valid_i <= 1'b0;
        col_q.push_back({pol_prev, exp});
        pol_prev = pol;
        while (col_q.size() != 0 || line_busy_o !== 1'b0) @(posedge core_clk_i);
    endtask
    task automatic send_dac(input logic sel);
        rnd = next_rand(rnd);
        if (rnd[7:0] == (sel ? dac_model[15:8] : dac_model[7:0])) rnd = ~rnd;
        @(posedge core_clk_i);
        dac_valid_i <= 1'b1;
        dac_sel_i <= sel;
        dac_code_i <= rnd[7:0];
        do @(posedge core_clk_i); while (dac_ready_o !== 1'b1);
        dac_valid_i <= 1'b0;
        if (sel) dac_model[15:8] = rnd[7:0];
        else dac_model[7:0] = rnd[7:0];
        dac_q.push_back(dac_model);
        while (dac_q.size() != 0) @(posedge core_clk_i);
    endtask
    // ----------
    // Output watchers
    // ----------
    always @(posedge core_clk_i) begin
        if (!srst_i && column_outputs_o !== col_seen) begin
            col_seen = column_outputs_o;
            repeat (2) @(posedge core_clk_i);
            `CHK("columns", col_q.pop_front(), {column_polarity_o, column_outputs_o})
        end
    end
    always @(posedge core_clk_i) begin
        if (!srst_i && {dac_out1_o, dac_out0_o} !== dac_seen) begin
            dac_seen = {dac_out1_o, dac_out0_o};
            `CHK("dac", dac_q.pop_front(), dac_seen)
        end
    end
    // ----------
    // Main sequence
    // ----------
    initial begin
        repeat (5) @(posedge core_clk_i);
        srst_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        for (int k = 0; k < 8; k++) send_line(k[0], k[1], k[2]);
        $display("test lines done");
        send_dac(1'b0);
        send_dac(1'b1);
        send_dac(1'b1);
        send_dac(1'b0);
        $display("test serial done");
        for (int m = 0; m < 4; m++) begin
            @(posedge core_clk_i);
            mode_prog_i <= m[0];
            test_mode_i <= m[1];
            repeat (6) @(posedge core_clk_i);
            `CHK("mode", m[1] ? MODE_NORMAL : m[0], output_mode_o)
        end
        `CHK("overflow", 1'b0, load_overflow_o)
        $display("test mode done");
        end_sim;
    end
    initial begin
        #100000;
        n_errors++;
        end_sim;
    end
endmodule // test_decimating_column_loader
